// file: cfc_map.svh
// Constants for the CAN fault confinement block: register offsets,
// field positions, reset values and counter thresholds.
// Assumes inclusion by cfc_pkg, the design file and the test bench only.
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH

`define CFC_OFF_STATE 4'h0
`define CFC_OFF_TEC 4'h1
`define CFC_OFF_REC 4'h2
`define CFC_OFF_IRQ_STAT 4'h3
`define CFC_OFF_IRQ_MASK 4'h4
`define CFC_OFF_CTRL 4'h5

`define CFC_BIT_ERR 0
`define CFC_BIT_PASSIVE 1
`define CFC_BIT_BUSOFF 2
`define CFC_BIT_RECOVER 3
`define CFC_IRQ_W 4

`define CFC_CTRL_ACTIVE_FLAG_EN 0

`define CFC_PASSIVE_LIMIT 9'h080
`define CFC_BUSOFF_LIMIT 9'h0ff
`define CFC_CNT_W 9
`define CFC_CNT_MAX 9'h1ff
`define CFC_RECESSIVE_RUN 4'hb
`define CFC_RECOVERY_RUNS 8'h80
`define CFC_RST_MASK 4'h0
`define CFC_RST_CTRL 1'h1

`endif

// file: cfc_pkg.sv
// Types shared by the fault confinement block.
// Assumes the map header sits in the same folder.
`include "cfc_map.svh"

package cfc_pkg;
    typedef enum logic [1:0] {
        CFC_ERR_ACTIVE,
        CFC_ERR_PASSIVE,
        CFC_BUS_OFF
    } cfc_state_t;
endpackage

// file: cfc_fault_conf.sv
// CAN fault confinement: error counters, error state, active error flag
// gating, automatic bus off recovery, Avalon-MM registers and interrupt.
// Assumes a protocol engine that reports errors and frame outcomes as
// one-cycle pulses and gives one pulse per sampled bit on bit_tick.
`timescale 1ns/100ps
`default_nettype none
`include "cfc_map.svh"

// Behaviour
// - Error active node joins traffic and drives an active error flag on errors.
// - Either counter reaching 128 moves the node to error passive.
// - Error passive node still transfers frames but sends no error flags.
// - Error flags are made and handled in hardware, unseen by software.
// - Transmit counter above 255 puts the node bus off.
// - Bus off blocks traffic until 128 runs of 11 recessive bits or reset.
// - After the recessive runs the node returns alone to error active.
// - Current error state is readable by software at any time.
// - Separate interrupt enables for single error, passive and bus off entry.
// - With single-error interrupt enabled, every error detected outside bus off interrupts.
// - Counters rise on errors, fall on successful transmit or receive.
module cfc_fault_conf #(
    parameter int TX_ERR_STEP = 8,
    parameter int RX_ERR_STEP = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bit_tick,
    input wire logic bus_bit_recessive,
    input wire logic err_detect,
    input wire logic tx_err,
    input wire logic rx_err,
    input wire logic tx_ok,
    input wire logic rx_ok,
    output logic active_flag_req,
    output logic node_online,
    output cfc_pkg::cfc_state_t err_state,
    output logic irq
);
    import cfc_pkg::*;

    localparam logic [8:0] TX_STEP = 9'(TX_ERR_STEP);
    localparam logic [8:0] RX_STEP = 9'(RX_ERR_STEP);

    cfc_state_t state_reg, state_next;
    logic [8:0] tec_reg, tec_next;
    logic [8:0] rec_reg, rec_next;
    logic [3:0] run_reg, run_next;
    logic [7:0] runs_reg, runs_next;
    logic [3:0] stat_reg, mask_reg;
    logic ctrl_reg;
    logic wait_reg;
    logic online_reg;
    logic [31:0] rdata_reg;
    logic flag_reg;
    logic irq_reg;

    // Bus side: one wait state on every access, answer on the second edge.
    wire logic req = avs_read | avs_write;
    wire logic take = req & ~wait_reg;
    wire logic wr_en = avs_write & take;
    wire logic wr_stat = wr_en && avs_address == `CFC_OFF_IRQ_STAT;
    wire logic wr_mask = wr_en && avs_address == `CFC_OFF_IRQ_MASK;
    wire logic wr_ctrl = wr_en && avs_address == `CFC_OFF_CTRL;

    wire logic is_off = state_reg == CFC_BUS_OFF;
    // A run ends on the recessive bit that brings the stored length to the
    // run length; the next-value count is already folded back to zero then.
    wire logic run_done = bit_tick && bus_bit_recessive
        && run_reg == `CFC_RECESSIVE_RUN - 4'h1;
    wire logic recovered = is_off && run_done
        && runs_reg == `CFC_RECOVERY_RUNS - 8'h01;
    wire logic tx_sat = tec_reg > `CFC_CNT_MAX - TX_STEP;
    wire logic rx_sat = rec_reg > `CFC_CNT_MAX - RX_STEP;
    wire logic enter_passive = state_reg == CFC_ERR_ACTIVE
        && state_next == CFC_ERR_PASSIVE;
    wire logic enter_off = !is_off && state_next == CFC_BUS_OFF;
    wire logic err_evt = err_detect && !is_off;
    wire logic [3:0] evt = {recovered, enter_off, enter_passive, err_evt};
    // A hardware set wins over a software clear in the same cycle.
    wire logic [3:0] stat_next = (stat_reg & ~(wr_stat ?
        avs_writedata[3:0] : 4'h0)) | evt;

    wire logic [31:0] rd_mux =
        avs_address == `CFC_OFF_STATE ? {30'h0, state_reg} :
        avs_address == `CFC_OFF_TEC ? {23'h0, tec_reg} :
        avs_address == `CFC_OFF_REC ? {23'h0, rec_reg} :
        avs_address == `CFC_OFF_IRQ_STAT ? {28'h0, stat_reg} :
        avs_address == `CFC_OFF_IRQ_MASK ? {28'h0, mask_reg} :
        avs_address == `CFC_OFF_CTRL ? {31'h0, ctrl_reg} : 32'h0;

    // Counters saturate so a storm of errors never wraps back to zero.
    always_comb begin
        tec_next = tec_reg;
        rec_next = rec_reg;
        if (is_off) begin
            if (recovered) begin
                tec_next = 9'h000;
                rec_next = 9'h000;
            end
        end else begin
            if (tx_err) begin
                tec_next = tx_sat ? `CFC_CNT_MAX : tec_reg + TX_STEP;
            end else if (tx_ok && tec_reg != 9'h000) begin
                tec_next = tec_reg - 9'h001;
            end
            if (rx_err) begin
                rec_next = rx_sat ? `CFC_CNT_MAX : rec_reg + RX_STEP;
            end else if (rx_ok && rec_reg != 9'h000) begin
                rec_next = rec_reg - 9'h001;
            end
        end
    end

    always_comb begin
        case (state_reg)
            CFC_ERR_ACTIVE, CFC_ERR_PASSIVE: begin
                if (tec_next > `CFC_BUSOFF_LIMIT) begin
                    state_next = CFC_BUS_OFF;
                end else if (tec_next >= `CFC_PASSIVE_LIMIT
                        || rec_next >= `CFC_PASSIVE_LIMIT) begin
                    state_next = CFC_ERR_PASSIVE;
                end else begin
                    state_next = CFC_ERR_ACTIVE;
                end
            end
            CFC_BUS_OFF: begin
                state_next = recovered ? CFC_ERR_ACTIVE : CFC_BUS_OFF;
            end
            default: state_next = CFC_ERR_ACTIVE;
        endcase
    end

    // Recovery counts runs of recessive bits only while bus off.
    always_comb begin
        run_next = run_reg;
        runs_next = runs_reg;
        if (!is_off) begin
            run_next = 4'h0;
            runs_next = 8'h00;
        end else if (bit_tick) begin
            if (!bus_bit_recessive) begin
                run_next = 4'h0;
            end else begin
                run_next = run_reg + 4'h1;
                if (run_done) begin
                    run_next = 4'h0;
                    runs_next = runs_reg + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= CFC_ERR_ACTIVE;
            tec_reg <= 9'h000;
            rec_reg <= 9'h000;
            run_reg <= 4'h0;
            runs_reg <= 8'h00;
            online_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            online_reg <= state_next != CFC_BUS_OFF;
            tec_reg <= tec_next;
            rec_reg <= rec_next;
            run_reg <= run_next;
            runs_reg <= runs_next;
        end
    end

    // Error flags never reach software; only the request pin shows them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= err_detect && state_reg == CFC_ERR_ACTIVE
                && ctrl_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_reg <= 4'h0;
            mask_reg <= `CFC_RST_MASK;
            ctrl_reg <= `CFC_RST_CTRL;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg <= |(stat_next & (wr_mask ? avs_writedata[3:0]
                : mask_reg));
            if (wr_mask) begin
                mask_reg <= avs_writedata[3:0];
            end
            if (wr_ctrl) begin
                ctrl_reg <= avs_writedata[`CFC_CTRL_ACTIVE_FLAG_EN];
            end
        end
    end

    // Waitrequest drops for one cycle only, so a request still held after it
    // is taken again two cycles later.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~(req & wait_reg);
            rdata_reg <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign active_flag_req = flag_reg;
    assign node_online = online_reg;
    assign err_state = state_reg;
    assign irq = irq_reg;

    // Assertions.
    property p_flag_active;
        @(posedge clk) disable iff (!rst_b)
        err_detect && state_reg == CFC_ERR_ACTIVE && ctrl_reg
            |=> active_flag_req;
    endproperty
    a_flag_active: assert property (p_flag_active)
        else $error("active error flag missing");

    property p_passive_entry;
        @(posedge clk) disable iff (!rst_b)
        state_reg == CFC_ERR_ACTIVE && rec_reg == 9'h07f && rx_err
            && tec_reg < 9'h080 |=> err_state == CFC_ERR_PASSIVE;
    endproperty
    a_passive_entry: assert property (p_passive_entry)
        else $error("passive state not entered at 128");

    property p_no_flag_passive;
        @(posedge clk) disable iff (!rst_b)
        state_reg != CFC_ERR_ACTIVE |=> !active_flag_req;
    endproperty
    a_no_flag_passive: assert property (p_no_flag_passive)
        else $error("error flag sent while not active");

    property p_busoff;
        @(posedge clk) disable iff (!rst_b)
        tec_reg > 9'h0ff |-> err_state == CFC_BUS_OFF;
    endproperty
    a_busoff: assert property (p_busoff)
        else $error("bus off not held above 255");

    property p_offline;
        @(posedge clk) disable iff (!rst_b)
        node_online == (err_state != CFC_BUS_OFF);
    endproperty
    a_offline: assert property (p_offline)
        else $error("node online during bus off");

    property p_recover;
        @(posedge clk) disable iff (!rst_b)
        recovered |=> err_state == CFC_ERR_ACTIVE && tec_reg == 9'h000
            && node_online;
    endproperty
    a_recover: assert property (p_recover)
        else $error("no recovery after recessive runs");

    property p_no_early_recover;
        @(posedge clk) disable iff (!rst_b)
        is_off && runs_reg < 8'h7f |=> err_state == CFC_BUS_OFF;
    endproperty
    a_no_early_recover: assert property (p_no_early_recover)
        else $error("left bus off too early");

    property p_err_sticky;
        @(posedge clk) disable iff (!rst_b)
        err_evt |=> stat_reg[`CFC_BIT_ERR]
            && (irq || !mask_reg[`CFC_BIT_ERR]);
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("single error not latched");

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_b)
        irq == |(stat_reg & mask_reg);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enabled cause");

    property p_counter_up;
        @(posedge clk) disable iff (!rst_b)
        !is_off && tx_err && tec_reg < 9'h0f0 |=> tec_reg ==
            $past(tec_reg) + TX_STEP;
    endproperty
    a_counter_up: assert property (p_counter_up)
        else $error("transmit counter did not step");

    property p_reset_state;
        @(posedge clk) $rose(rst_b) |-> err_state == CFC_ERR_ACTIVE
            && tec_reg == 9'h000 && runs_reg == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");

    c_passive: cover property (@(posedge clk) disable iff (!rst_b)
        enter_passive);
    c_busoff: cover property (@(posedge clk) disable iff (!rst_b)
        enter_off);
    c_recover: cover property (@(posedge clk) disable iff (!rst_b)
        recovered);
    c_irq: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(irq));
endmodule
`default_nettype wire

// file: cfc_bus_node.sv
// Behavioural stand-in for the other nodes on the CAN bus, as seen through
// the protocol engine: one bit_tick pulse per sampled bit with its level.
// Assumes the bench calls send() right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module cfc_bus_node (
    input wire logic clk,
    output logic bit_tick,
    output logic bus_bit_recessive
);
    initial begin
        bit_tick = 1'b0;
        bus_bit_recessive = 1'b0;
    end

    // Between ticks the level shows the inverse of the last bit, so a
    // design that samples off the tick sees a wrong value.
    task automatic send(input int n, input logic rec);
        repeat (n) begin
            repeat (3) @(posedge clk);
            bit_tick <= 1'b1;
            bus_bit_recessive <= rec;
            @(posedge clk);
            bit_tick <= 1'b0;
            bus_bit_recessive <= ~rec;
        end
    endtask
endmodule
`default_nettype wire

// file: can_fault_confinement_states_test.sv
// Self-checking bench for the fault confinement block: register reads and
// writes over Avalon-MM, error pulses from the bench, bus bits from a model.
// Assumes the design and map header compile before this file.
`timescale 1ns/100ps
`default_nettype none
`include "cfc_map.svh"
module can_fault_confinement_states_test;
    import cfc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic bit_tick;
    logic bus_bit_recessive;
    logic [4:0] evs = 5'h0;
    logic active_flag_req;
    logic node_online;
    cfc_state_t err_state;
    logic irq;
    int fail_count = 0;
    int n_compared = 0;
    int flag_n = 0;

    always #4 clk = ~clk;

    cfc_bus_node u_node (.clk(clk), .bit_tick(bit_tick),
        .bus_bit_recessive(bus_bit_recessive));

    cfc_fault_conf dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bit_tick(bit_tick),
        .bus_bit_recessive(bus_bit_recessive), .err_detect(evs[0]),
        .tx_err(evs[1]), .rx_err(evs[2]), .tx_ok(evs[3]), .rx_ok(evs[4]),
        .active_flag_req(active_flag_req), .node_online(node_online),
        .err_state(err_state), .irq(irq));

    always @(posedge clk) begin
        if (active_flag_req === 1'b1) begin
            flag_n++;
        end
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access; an edge passes first so a request is never re-raised in
    // the time step that dropped the previous one.
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic ev(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            evs[k] <= 1'b1;
            @(posedge clk);
            evs[k] <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(`CFC_OFF_STATE, 32'h0);
        rd(`CFC_OFF_TEC, 32'h0);
        rd(`CFC_OFF_REC, 32'h0);
        rd(`CFC_OFF_IRQ_MASK, 32'h0);
        rd(`CFC_OFF_CTRL, 32'h1);
        rd(4'h6, 32'h0);
        wr(`CFC_OFF_TEC, 32'h5);
        rd(`CFC_OFF_TEC, 32'h0);
        chk(node_online, 1'b1);
        wr(`CFC_OFF_IRQ_MASK, 32'h1);
        ev(0, 1);
        chk(flag_n, 1);
        chk(irq, 1'b1);
        rd(`CFC_OFF_IRQ_STAT, 32'h1);
        wr(`CFC_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(`CFC_OFF_CTRL, 32'h0);
        ev(0, 1);
        chk(flag_n, 1);
        chk(irq, 1'b1);
        wr(`CFC_OFF_CTRL, 32'h1);
        wr(`CFC_OFF_IRQ_STAT, 32'hf);
        wr(`CFC_OFF_IRQ_MASK, 32'h2);
        ev(2, 127);
        rd(`CFC_OFF_REC, 32'd127);
        rd(`CFC_OFF_STATE, 32'h0);
        chk(irq, 1'b0);
        ev(2, 1);
        rd(`CFC_OFF_STATE, 32'h1);
        chk(irq, 1'b1);
        ev(0, 1);
        chk(flag_n, 1);
        ev(4, 1);
        rd(`CFC_OFF_REC, 32'd127);
        rd(`CFC_OFF_STATE, 32'h0);
        wr(`CFC_OFF_IRQ_STAT, 32'hf);
        wr(`CFC_OFF_IRQ_MASK, 32'h4);
        ev(1, 31);
        rd(`CFC_OFF_TEC, 32'd248);
        rd(`CFC_OFF_STATE, 32'h1);
        ev(1, 1);
        rd(`CFC_OFF_TEC, 32'd256);
        rd(`CFC_OFF_STATE, 32'h2);
        chk(node_online, 1'b0);
        chk(err_state, 32'h2);
        chk(irq, 1'b1);
        rd(`CFC_OFF_IRQ_STAT, 32'h6);
        ev(2, 1);
        rd(`CFC_OFF_REC, 32'd127);
        u_node.send(10, 1'b1);
        u_node.send(1, 1'b0);
        u_node.send(127 * 11, 1'b1);
        rd(`CFC_OFF_STATE, 32'h2);
        u_node.send(11, 1'b1);
        repeat (2) @(posedge clk);
        rd(`CFC_OFF_STATE, 32'h0);
        chk(node_online, 1'b1);
        rd(`CFC_OFF_TEC, 32'h0);
        rd(`CFC_OFF_REC, 32'h0);
        rd(`CFC_OFF_IRQ_STAT, 32'he);
        // Software reinitialises its registers once recovery is seen.
        wr(`CFC_OFF_IRQ_STAT, 32'hf);
        wr(`CFC_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        ev(0, 1);
        chk(flag_n, 2);
        ev(1, 32);
        rd(`CFC_OFF_STATE, 32'h2);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rd(`CFC_OFF_STATE, 32'h0);
        chk(node_online, 1'b1);
        rd(`CFC_OFF_TEC, 32'h0);
        rd(`CFC_OFF_IRQ_STAT, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
